// File: verilog/usbe_consts.vh
// Constants shared by the USB device endpoint engine files.
// Assumes a single 200 MHz clock domain and an external byte-level SIE.
`ifndef USBE_CONSTS_VH
`define USBE_CONSTS_VH

// Rates and times
`define USBE_CLK_KHZ 200000
`define USBE_FS_KBPS 12000
`define USBE_LS_KBPS 1500
`define USBE_SUSP_US 3000
`define USBE_RST_NS 2500
`define USBE_FS_SUSP_BITS (`USBE_SUSP_US * `USBE_FS_KBPS / 1000)
`define USBE_LS_SUSP_BITS (`USBE_SUSP_US * `USBE_LS_KBPS / 1000)
`define USBE_FS_RST_BITS ((`USBE_RST_NS * `USBE_FS_KBPS + 999999) / 1000000)
`define USBE_LS_RST_BITS ((`USBE_RST_NS * `USBE_LS_KBPS + 999999) / 1000000)

// Token and handshake codes
`define USBE_TOK_OUT 2'h0
`define USBE_TOK_IN 2'h1
`define USBE_TOK_SETUP 2'h2
`define USBE_HS_ACK 2'h0
`define USBE_HS_NAK 2'h1
`define USBE_HS_STALL 2'h2

// Descriptor: 8 bytes each, two per endpoint (16 bytes), bytes 0..6 used
`define USBE_DESC_LAST 3'h6
`define USBE_CTL_TYPE_LSB 0
`define USBE_CTL_STALL 3
`define USBE_CTL_ARMED 4
`define USBE_CTL_DONE 5
`define USBE_TYPE_CTRL 2'h0
`define USBE_TYPE_ISO 2'h1
`define USBE_TYPE_BULK 2'h2
`define USBE_TYPE_INT 2'h3

`endif

// File: verilog/usbe_lsmon.v
// Bus line state monitor: bit-rate tick, suspend, resume and bus reset.
// Assumes dp_i and dm_i come straight from the transceiver pins.
`timescale 1ns/1ps
`include "usbe_consts.vh"

module usbe_lsmon #(
   parameter [15:0] SUSP_FS = `USBE_FS_SUSP_BITS,
   parameter [15:0] SUSP_LS = `USBE_LS_SUSP_BITS
) (
   // Clock and reset
   input wire clock_i,
   input wire rstn_i,
   // Configuration
   input wire low_speed_i,
   input wire sleep_en_i,
   // Pins
   input wire dp_i,
   input wire dm_i,
   // Status
   output reg suspend_o,
   output reg sleep_req_o,
   output reg wake_o,
   output reg bus_reset_o
);

////////////////////////////////////////////////////////////////////////////
reg [2:0] dp_s_q;
reg [2:0] dm_s_q;
reg dp_q;
reg dm_q;
reg [17:0] acc_q;
reg [15:0] idle_q;
reg [5:0] se0_q;
wire [17:0] rate = low_speed_i ? 18'h0_05DC : 18'h0_2EE0;
localparam [17:0] CLK_W = `USBE_CLK_KHZ;
wire [17:0] sum = acc_q + rate;
wire tick = sum >= CLK_W;
wire j_st = low_speed_i ? (!dp_q && dm_q) : (dp_q && !dm_q);
wire k_st = low_speed_i ? (dp_q && !dm_q) : (!dp_q && dm_q);
wire se0 = !dp_q && !dm_q;
wire [15:0] susp_lim = low_speed_i ? SUSP_LS : SUSP_FS;
wire [5:0] rst_lim = low_speed_i ? 6'h04 : 6'h1E;

// Level accepted only once the last two stages agree
always @(posedge clock_i or negedge rstn_i) begin
   if (!rstn_i) begin
      dp_s_q <= 3'h0;
      dm_s_q <= 3'h0;
      dp_q <= 1'b0;
      dm_q <= 1'b0;
   end else begin
      dp_s_q <= {dp_s_q[1:0], dp_i};
      dm_s_q <= {dm_s_q[1:0], dm_i};
      if (dp_s_q[1] == dp_s_q[2])
         dp_q <= dp_s_q[2];
      if (dm_s_q[1] == dm_s_q[2])
         dm_q <= dm_s_q[2];
   end
end

////////////////////////////////////////////////////////////////////////////
// Fractional accumulator gives the bit-rate enable from the system clock
always @(posedge clock_i or negedge rstn_i) begin
   if (!rstn_i) begin
      acc_q <= 18'h0_0000;
      idle_q <= 16'h0000;
      se0_q <= 6'h00;
      suspend_o <= 1'b0;
      sleep_req_o <= 1'b0;
      wake_o <= 1'b0;
      bus_reset_o <= 1'b0;
   end else begin
      acc_q <= tick ? sum - CLK_W : sum;
      wake_o <= suspend_o && k_st;
      if (!j_st) begin
         idle_q <= 16'h0000;
         suspend_o <= 1'b0;
      end else if (tick && idle_q != susp_lim) begin
         idle_q <= idle_q + 16'h0001;
      end else if (idle_q == susp_lim) begin
         suspend_o <= 1'b1;
      end
      if (!se0)
         se0_q <= 6'h00;
      else if (tick && se0_q != rst_lim)
         se0_q <= se0_q + 6'h01;
      bus_reset_o <= se0 && se0_q == rst_lim;
      sleep_req_o <= suspend_o && sleep_en_i;
   end
end

endmodule

// File: verilog/usbe_engine.v
// Endpoint engine: token handling, descriptor DMA, packet data DMA,
// multi-packet and ping-pong sequencing, transaction-complete queue.
// Assumes an SIE on the same clock delivers tokens and bytes, and an
// SRAM port that grants requests and returns read data later.
`timescale 1ns/1ps
`include "usbe_consts.vh"

module usbe_engine #(
   parameter TCQ_AW = 4,
   parameter [15:0] SUSP_FS = `USBE_FS_SUSP_BITS,
   parameter [15:0] SUSP_LS = `USBE_LS_SUSP_BITS
) (
   // Clock and reset; clock_i is the dedicated bus clock
   input wire clock_i,
   input wire rstn_i,
   // Configuration
   input wire low_speed_i,
   input wire sleep_en_i,
   input wire tcq_irq_en_i,
   input wire [15:0] pp_en_i,
   input wire [15:0] desc_base_i,
   // Bus pins
   input wire dp_i,
   input wire dm_i,
   // Token from the SIE
   input wire tok_valid_i,
   input wire [1:0] tok_type_i,
   input wire [3:0] tok_ep_i,
   output wire tok_ready_o,
   // Received data
   input wire rx_valid_i,
   input wire [7:0] rx_data_i,
   input wire rx_end_i,
   input wire rx_ok_i,
   output wire rx_ready_o,
   // Transmit data
   output reg tx_valid_o,
   output reg [7:0] tx_data_o,
   output reg tx_last_o,
   output reg tx_empty_o,
   input wire tx_ready_i,
   // Host handshake after IN data
   input wire hs_ack_i,
   input wire hs_lost_i,
   // Device handshake
   output reg hs_valid_o,
   output reg [1:0] hs_code_o,
   // SRAM master
   output wire mem_req_o,
   output wire mem_we_o,
   output wire [15:0] mem_addr_o,
   output wire [7:0] mem_wdata_o,
   input wire mem_gnt_i,
   input wire mem_rvalid_i,
   input wire [7:0] mem_rdata_i,
   // Transaction-complete queue
   output wire tcq_valid_o,
   output reg [4:0] tcq_data_o,
   input wire tcq_pop_i,
   output reg tcq_irq_o,
   // Power
   output wire suspend_o,
   output wire sleep_req_o,
   output wire wake_o,
   output wire bus_reset_o
);

////////////////////////////////////////////////////////////////////////////
localparam [7:0] S_IDLE = 8'h01;
localparam [7:0] S_FETCH = 8'h02;
localparam [7:0] S_DEC = 8'h04;
localparam [7:0] S_TX = 8'h08;
localparam [7:0] S_RX = 8'h10;
localparam [7:0] S_WACK = 8'h20;
localparam [7:0] S_WB = 8'h40;
localparam [7:0] S_HSK = 8'h80;
localparam TCQ_N = 1 << TCQ_AW;

// Descriptor of an endpoint: 16 bytes per address, 8 per direction, or per bank when ping-pong is on
function [15:0] desc_addr;
   input [15:0] base;
   input [3:0] ep;
   input sel;
   input [2:0] idx;
   begin
      desc_addr = base + {8'h00, ep, sel, idx};
   end
endfunction

function [9:0] min_len;
   input [15:0] cnt;
   input [9:0] mps;
   begin
      min_len = (cnt < {6'h00, mps}) ? cnt[9:0] : mps;
   end
endfunction

reg [7:0] state_q;
reg [3:0] ep_q;
reg dir_q;
reg setup_q;
reg [15:0] bank_q;
reg [2:0] idx_q;
reg rd_wait_q;
reg [7:0] ctrl_q;
reg [9:0] mps_q;
reg [15:0] ptr_q;
reg [15:0] cnt_q;
reg [9:0] n_q;
reg [9:0] plen_q;
reg [7:0] rxb_q;
reg rxp_q;
reg drop_q;
reg end_q;
reg ok_q;
reg comp_q;
reg [4:0] tcq_mem [0:TCQ_N-1];
reg [TCQ_AW:0] wr_q;
reg [TCQ_AW:0] rd_q;

wire pp = pp_en_i[ep_q];
wire dsel = pp ? bank_q[ep_q] : dir_q;
wire iso = ctrl_q[1:0] == `USBE_TYPE_ISO;
wire tcq_full = (wr_q ^ rd_q) == {1'b1, {TCQ_AW{1'b0}}};
wire tx_fetch = state_q == S_TX && !rd_wait_q && !tx_valid_o &&
   n_q < plen_q;
wire wr_go = state_q == S_WB && mem_gnt_i;
wire wb_end = wr_go && idx_q == `USBE_DESC_LAST;
wire push = wb_end && comp_q;
wire [9:0] plen_w = min_len(cnt_q, mps_q);
reg [7:0] wb_byte;

assign tok_ready_o = state_q == S_IDLE && !tcq_full;
assign rx_ready_o = state_q == S_RX && !rxp_q && !end_q;
assign tcq_valid_o = wr_q != rd_q;

////////////////////////////////////////////////////////////////////////////
// Memory master; the block holds no endpoint storage of its own
assign mem_req_o = (state_q == S_FETCH && !rd_wait_q) || tx_fetch ||
   (state_q == S_RX && rxp_q) || state_q == S_WB;
assign mem_we_o = state_q == S_RX || state_q == S_WB;
assign mem_addr_o = (state_q == S_TX || state_q == S_RX) ?
   ptr_q + {6'h00, n_q} : desc_addr(desc_base_i, ep_q, dsel, idx_q);
assign mem_wdata_o = state_q == S_RX ? rxb_q : wb_byte;

always @* begin
   case (idx_q)
      3'h0: wb_byte = comp_q ? (ctrl_q & 8'hEF) | 8'h20 : ctrl_q;
      3'h1: wb_byte = mps_q[7:0];
      3'h2: wb_byte = {6'h00, mps_q[9:8]};
      3'h3: wb_byte = ptr_q[7:0];
      3'h4: wb_byte = ptr_q[15:8];
      3'h5: wb_byte = cnt_q[7:0];
      default: wb_byte = cnt_q[15:8];
   endcase
end

////////////////////////////////////////////////////////////////////////////
// Transaction sequencer
always @(posedge clock_i or negedge rstn_i) begin
   if (!rstn_i) begin
      state_q <= S_IDLE;
      ep_q <= 4'h0;
      dir_q <= 1'b0;
      setup_q <= 1'b0;
      bank_q <= 16'h0000;
      idx_q <= 3'h0;
      rd_wait_q <= 1'b0;
      ctrl_q <= 8'h00;
      mps_q <= 10'h000;
      ptr_q <= 16'h0000;
      cnt_q <= 16'h0000;
      n_q <= 10'h000;
      plen_q <= 10'h000;
      rxb_q <= 8'h00;
      rxp_q <= 1'b0;
      drop_q <= 1'b0;
      end_q <= 1'b0;
      ok_q <= 1'b0;
      comp_q <= 1'b0;
      tx_valid_o <= 1'b0;
      tx_data_o <= 8'h00;
      tx_last_o <= 1'b0;
      tx_empty_o <= 1'b0;
      hs_valid_o <= 1'b0;
      hs_code_o <= `USBE_HS_ACK;
   end else if (bus_reset_o) begin
      state_q <= S_IDLE;
      bank_q <= 16'h0000;
      rd_wait_q <= 1'b0;
      rxp_q <= 1'b0;
      tx_valid_o <= 1'b0;
      hs_valid_o <= 1'b0;
   end else begin
      hs_valid_o <= 1'b0;
      case (state_q)
         S_IDLE: begin
            if (tok_valid_i && tok_ready_o) begin
               ep_q <= tok_ep_i;
               dir_q <= tok_type_i == `USBE_TOK_IN;
               setup_q <= tok_type_i == `USBE_TOK_SETUP;
               idx_q <= 3'h0;
               state_q <= S_FETCH;
            end
         end
         S_FETCH: begin
            if (mem_gnt_i)
               rd_wait_q <= 1'b1;
            if (mem_rvalid_i) begin
               rd_wait_q <= 1'b0;
               case (idx_q)
                  3'h0: ctrl_q <= mem_rdata_i;
                  3'h1: mps_q[7:0] <= mem_rdata_i;
                  3'h2: mps_q[9:8] <= mem_rdata_i[1:0];
                  3'h3: ptr_q[7:0] <= mem_rdata_i;
                  3'h4: ptr_q[15:8] <= mem_rdata_i;
                  3'h5: cnt_q[7:0] <= mem_rdata_i;
                  default: cnt_q[15:8] <= mem_rdata_i;
               endcase
               if (idx_q == `USBE_DESC_LAST)
                  state_q <= S_DEC;
               else
                  idx_q <= idx_q + 3'h1;
            end
         end
         S_DEC: begin
            n_q <= 10'h000;
            plen_q <= plen_w;
            drop_q <= 1'b0;
            end_q <= 1'b0;
            ok_q <= 1'b0;
            // SETUP on a control address is always taken
            if (setup_q && ctrl_q[1:0] == `USBE_TYPE_CTRL) begin
               state_q <= S_RX;
            end else if (ctrl_q[`USBE_CTL_STALL]) begin
               hs_code_o <= `USBE_HS_STALL;
               state_q <= S_HSK;
            end else if (!ctrl_q[`USBE_CTL_ARMED]) begin
               hs_code_o <= `USBE_HS_NAK;
               state_q <= S_HSK;
            end else if (dir_q) begin
               tx_valid_o <= plen_w == 10'h000;
               tx_last_o <= plen_w == 10'h000;
               tx_empty_o <= plen_w == 10'h000;
               state_q <= S_TX;
            end else begin
               state_q <= S_RX;
            end
         end
         S_TX: begin
            if (tx_fetch && mem_gnt_i)
               rd_wait_q <= 1'b1;
            if (mem_rvalid_i && rd_wait_q) begin
               rd_wait_q <= 1'b0;
               tx_valid_o <= 1'b1;
               tx_data_o <= mem_rdata_i;
               tx_last_o <= n_q + 10'h001 == plen_q;
               tx_empty_o <= 1'b0;
            end
            if (tx_valid_o && tx_ready_i) begin
               tx_valid_o <= 1'b0;
               if (!tx_empty_o)
                  n_q <= n_q + 10'h001;
               if (tx_last_o)
                  state_q <= S_WACK;
               idx_q <= 3'h0;
            end
         end
         S_WACK: begin
            // Iso data gets no host handshake
            if (hs_ack_i || iso)
               state_q <= S_WB;
            else if (hs_lost_i)
               state_q <= S_IDLE;
         end
         S_RX: begin
            if (rx_valid_i && rx_ready_o) begin
               if (n_q + {9'h000, rxp_q} < plen_q) begin
                  rxb_q <= rx_data_i;
                  rxp_q <= 1'b1;
               end else begin
                  drop_q <= 1'b1;
               end
            end
            if (rxp_q && mem_gnt_i) begin
               rxp_q <= 1'b0;
               n_q <= n_q + 10'h001;
            end
            if (rx_end_i) begin
               end_q <= 1'b1;
               ok_q <= rx_ok_i;
            end
            if (end_q && !rxp_q) begin
               idx_q <= 3'h0;
               if (ok_q && !drop_q) begin
                  hs_valid_o <= !iso;
                  hs_code_o <= `USBE_HS_ACK;
                  state_q <= S_WB;
               end else begin
                  // Bad or oversized packet: stay silent, host retries
                  state_q <= S_IDLE;
               end
            end
         end
         S_WB: begin
            if (wr_go) begin
               idx_q <= idx_q + 3'h1;
               if (wb_end) begin
                  state_q <= S_IDLE;
                  if (comp_q && pp)
                     bank_q[ep_q] <= ~bank_q[ep_q];
               end
            end
         end
         S_HSK: begin
            hs_valid_o <= !iso;
            state_q <= S_IDLE;
         end
         default: state_q <= S_IDLE;
      endcase
      // Pointer and count advance once per accepted packet
      if ((state_q == S_WACK && (hs_ack_i || iso)) ||
         (state_q == S_RX && end_q && !rxp_q && ok_q && !drop_q)) begin
         ptr_q <= ptr_q + {6'h00, n_q};
         cnt_q <= cnt_q - {6'h00, n_q};
         comp_q <= setup_q || n_q < mps_q ||
            cnt_q == {6'h00, n_q};
      end
   end
end

////////////////////////////////////////////////////////////////////////////
// Transaction-complete queue; a token is refused while it is full
always @(posedge clock_i or negedge rstn_i) begin
   if (!rstn_i) begin
      wr_q <= {(TCQ_AW + 1){1'b0}};
      rd_q <= {(TCQ_AW + 1){1'b0}};
      tcq_data_o <= 5'h00;
      tcq_irq_o <= 1'b0;
   end else begin
      tcq_irq_o <= push && tcq_irq_en_i;
      if (push) begin
         tcq_mem[wr_q[TCQ_AW-1:0]] <= {ep_q, dsel};
         wr_q <= wr_q + {{TCQ_AW{1'b0}}, 1'b1};
      end
      if (tcq_pop_i && tcq_valid_o)
         rd_q <= rd_q + {{TCQ_AW{1'b0}}, 1'b1};
      tcq_data_o <= tcq_mem[rd_q[TCQ_AW-1:0]];
   end
end

////////////////////////////////////////////////////////////////////////////
// Line monitor on the same bus clock, chosen apart from the CPU clock
usbe_lsmon #(
   .SUSP_FS(SUSP_FS),
   .SUSP_LS(SUSP_LS)
) u_lsmon (
   .clock_i(clock_i),
   .rstn_i(rstn_i),
   .low_speed_i(low_speed_i),
   .sleep_en_i(sleep_en_i),
   .dp_i(dp_i),
   .dm_i(dm_i),
   .suspend_o(suspend_o),
   .sleep_req_o(sleep_req_o),
   .wake_o(wake_o),
   .bus_reset_o(bus_reset_o)
);

endmodule

// File: test/usbe_sram_model.sv
// SRAM model answering the engine's memory master.
// Assumes the bench loads and inspects ram directly between transfers.
`timescale 1ns/1ps

module usbe_sram_model (
   // Clock and reset
   input wire clock_i,
   input wire rstn_i,
   // Grant only every other cycle when set
   input wire slow_i,
   // Memory port
   input wire mem_req_i,
   input wire mem_we_i,
   input wire [15:0] mem_addr_i,
   input wire [7:0] mem_wdata_i,
   output wire mem_gnt_o,
   output reg mem_rvalid_o,
   output reg [7:0] mem_rdata_o
);
   reg [7:0] ram [0:4095];
   reg hold_q;
   wire take;

   assign mem_gnt_o = mem_req_i && !(slow_i && hold_q);
   assign take = mem_req_i && mem_gnt_o;

   always @(posedge clock_i or negedge rstn_i) begin
      if (!rstn_i) begin
         hold_q <= 1'b1;
         mem_rvalid_o <= 1'b0;
         mem_rdata_o <= 8'h00;
      end else begin
         hold_q <= mem_req_i ? !hold_q : 1'b1;
         mem_rvalid_o <= take && !mem_we_i;
         // Data churns outside a read so a stale byte never passes
         if (take && !mem_we_i)
            mem_rdata_o <= ram[mem_addr_i[11:0]];
         else
            mem_rdata_o <= ~mem_rdata_o;
         if (take && mem_we_i)
            ram[mem_addr_i[11:0]] <= mem_wdata_i;
      end
   end
endmodule

// File: test/usbe_engine_asserts.sv
// Port checker for the endpoint engine.
// Assumes one clock domain; bound to usbe_engine from the bench top.
`timescale 1ns/1ps

module usbe_engine_chk #(
   parameter TCQ_AW = 4,
   parameter [15:0] SUSP_FS = 16'h0028,
   parameter [15:0] SUSP_LS = 16'h0028
) (
   // Clock and reset
   input wire clock_i,
   input wire rstn_i,
   // Inputs
   input wire sleep_en_i,
   input wire tcq_irq_en_i,
   input wire [15:0] desc_base_i,
   input wire tok_valid_i,
   input wire [3:0] tok_ep_i,
   input wire tx_ready_i,
   input wire hs_ack_i,
   input wire mem_gnt_i,
   // Outputs
   input wire tok_ready_o,
   input wire tx_valid_o,
   input wire [7:0] tx_data_o,
   input wire tx_last_o,
   input wire hs_valid_o,
   input wire mem_req_o,
   input wire mem_we_o,
   input wire [15:0] mem_addr_o,
   input wire tcq_valid_o,
   input wire tcq_irq_o,
   input wire suspend_o,
   input wire sleep_req_o,
   input wire wake_o
);
   default clocking cb @(posedge clock_i);
   endclocking
   default disable iff (!rstn_i);

   ////////////////////////////////////////
   // Descriptor writeback after an ACKed IN packet
   sequence s_wb;
      ##[1:200] (mem_req_o && mem_we_o && mem_gnt_i);
   endsequence
   property p_tok_fetch;
      tok_valid_i && tok_ready_o |=> mem_req_o && !mem_we_o &&
         ((mem_addr_o - desc_base_i) & 16'hfff7) ==
         {8'h00, $past(tok_ep_i), 4'h0};
   endproperty
   property p_busy;
      mem_req_o |-> !tok_ready_o;
   endproperty
   property p_mem_hold;
      mem_req_o && !mem_gnt_i |=> mem_req_o && $stable(mem_addr_o) &&
         $stable(mem_we_o);
   endproperty
   property p_tx_hold;
      tx_valid_o && !tx_ready_i |=> tx_valid_o && $stable(tx_data_o) &&
         $stable(tx_last_o);
   endproperty
   property p_hs_pulse;
      hs_valid_o |=> !hs_valid_o;
   endproperty
   property p_wb;
      hs_ack_i |-> s_wb;
   endproperty
   property p_irq;
      tcq_irq_o |-> tcq_valid_o && $past(tcq_irq_en_i) ##1 !tcq_irq_o;
   endproperty
   property p_sleep;
      sleep_req_o |-> $past(suspend_o) && $past(sleep_en_i);
   endproperty
   property p_wake;
      $rose(wake_o) |-> $past(suspend_o);
   endproperty

   a_tok_fetch: assert property (p_tok_fetch)
      else $error("descriptor fetch misplaced");
   a_busy: assert property (p_busy)
      else $error("token accepted while busy");
   a_mem_hold: assert property (p_mem_hold)
      else $error("memory request changed before grant");
   a_tx_hold: assert property (p_tx_hold)
      else $error("transmit byte changed before ready");
   a_hs_pulse: assert property (p_hs_pulse)
      else $error("handshake longer than one cycle");
   a_wb: assert property (p_wb)
      else $error("no writeback after host ack");
   a_irq: assert property (p_irq)
      else $error("queue interrupt without entry or enable");
   a_sleep: assert property (p_sleep)
      else $error("sleep request outside suspend");
   a_wake: assert property (p_wake)
      else $error("wake outside suspend");
endmodule

// File: test/tb.sv
// Self-checking bench for the endpoint engine.
// Assumes the SRAM model and checker files compiled alongside.
`timescale 1ns/1ps
`include "usbe_consts.vh"

module tb;
   localparam [15:0] BASE = 16'h0100;
   reg clock_i = 1'b0;
   reg rstn_i = 1'b0;
   reg low_speed_i = 1'b0;
   reg sleep_en_i = 1'b1;
   reg tcq_irq_en_i = 1'b1;
   reg [15:0] pp_en_i = 16'h0000;
   reg tok_valid_i = 1'b0;
   reg [1:0] tok_type_i = 2'h0;
   reg [3:0] tok_ep_i = 4'h0;
   reg rx_valid_i = 1'b0;
   reg [7:0] rx_data_i = 8'h00;
   reg rx_end_i = 1'b0;
   reg rx_ok_i = 1'b0;
   reg tx_ready_i = 1'b0;
   reg hs_ack_i = 1'b0;
   reg hs_lost_i = 1'b0;
   reg tcq_pop_i = 1'b0;
   reg slow = 1'b0;
   reg traffic = 1'b1;
   reg se0 = 1'b0;
   reg line_q = 1'b1;
   reg [15:0] cyc = 16'h0000;
   integer failures = 0;
   integer check_count = 0;
   integer irq_cnt = 0;
   integer n0;
   // Toggling J and K keeps the line busy so suspend stays away
   wire dp_i = !se0 && (traffic ? cyc[4] : line_q);
   wire dm_i = !dp_i && !se0;
   wire tok_ready_o, rx_ready_o, tx_valid_o, tx_last_o, tx_empty_o;
   wire hs_valid_o, mem_req_o, mem_we_o, mem_gnt_i, mem_rvalid_i;
   wire tcq_valid_o, tcq_irq_o, suspend_o, sleep_req_o, wake_o;
   wire bus_reset_o;
   wire [7:0] tx_data_o, mem_wdata_o, mem_rdata_i;
   wire [1:0] hs_code_o;
   wire [15:0] mem_addr_o;
   wire [4:0] tcq_data_o;

   // Short suspend count keeps the low speed run brief
   usbe_engine #(.TCQ_AW(4), .SUSP_FS(16'h0028), .SUSP_LS(16'h0028)) DUT (
      .desc_base_i(BASE),
      .*
   );
   usbe_sram_model mem (
      .clock_i(clock_i),
      .rstn_i(rstn_i),
      .slow_i(slow),
      .mem_req_i(mem_req_o),
      .mem_we_i(mem_we_o),
      .mem_addr_i(mem_addr_o),
      .mem_wdata_i(mem_wdata_o),
      .mem_gnt_o(mem_gnt_i),
      .mem_rvalid_o(mem_rvalid_i),
      .mem_rdata_o(mem_rdata_i)
   );

   always #2.5 clock_i = ~clock_i;

   always @(posedge clock_i) begin
      cyc <= cyc + 16'h0001;
      if (tcq_irq_o === 1'b1)
         irq_cnt <= irq_cnt + 1;
      if (cyc == 16'h7530) begin
         failures = failures + 1;
         results;
      end
   end

   ////////////////////////////////////////
   task results;
      begin
         if (failures == 0 && check_count > 0)
            $display("[ PASS ]");
         else
            $display("[ FAIL ]");
         $finish;
      end
   endtask

   task cmp(input [15:0] got, input [15:0] exp);
      begin
         check_count = check_count + 1;
         if (got !== exp) begin
            failures = failures + 1;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
         end
      end
   endtask

   task tick;
      begin
         @(posedge clock_i);
         #1;
      end
   endtask

   task desc(input [3:0] ep, input sel, input [7:0] ctl,
         input [15:0] mps, input [15:0] ptr, input [15:0] cnt);
      reg [11:0] a;
      begin
         a = BASE[11:0] + {4'h0, ep, sel, 3'h0};
         mem.ram[a] = ctl;
         mem.ram[a + 12'h001] = mps[7:0];
         mem.ram[a + 12'h002] = mps[15:8];
         mem.ram[a + 12'h003] = ptr[7:0];
         mem.ram[a + 12'h004] = ptr[15:8];
         mem.ram[a + 12'h005] = cnt[7:0];
         mem.ram[a + 12'h006] = cnt[15:8];
      end
   endtask

   task token(input [1:0] typ, input [3:0] ep);
      integer n;
      begin
         tok_type_i = typ;
         tok_ep_i = ep;
         tok_valid_i = 1'b1;
         n = 0;
         @(negedge clock_i);
         while (tok_ready_o !== 1'b1 && n < 400) begin
            @(negedge clock_i);
            n = n + 1;
         end
         tick;
         tok_valid_i = 1'b0;
         cmp(n < 400, 1'b1);
      end
   endtask

   task exp_hs(input present, input [1:0] code);
      integer n;
      reg seen;
      reg [1:0] c;
      begin
         seen = 1'b0;
         c = 2'h0;
         for (n = 0; n < 100 && !seen; n = n + 1) begin
            @(negedge clock_i);
            if (hs_valid_o === 1'b1) begin
               seen = 1'b1;
               c = hs_code_o;
            end
         end
         cmp({seen, c}, {present, present ? code : 2'h0});
         tick;
      end
   endtask

   task in_pkt(input integer n, input [11:0] ptr, input ack);
      integer i;
      integer k;
      begin
         i = 0;
         for (k = 0; k < 300 && i < n; k = k + 1) begin
            @(negedge clock_i);
            if (tx_valid_o === 1'b1 && tx_ready_i === 1'b1) begin
               cmp(tx_data_o, mem.ram[ptr + i[11:0]]);
               cmp({tx_last_o, tx_empty_o}, {i == n - 1, 1'b0});
               i = i + 1;
            end
            tick;
            tx_ready_i = (i < n) && (!slow || !tx_ready_i);
         end
         cmp(i, n);
         hs_ack_i = ack;
         hs_lost_i = !ack;
         tick;
         hs_ack_i = 1'b0;
         hs_lost_i = 1'b0;
      end
   endtask

   task pop(input [4:0] exp);
      integer k;
      begin
         k = 0;
         @(negedge clock_i);
         while (tcq_valid_o !== 1'b1 && k < 300) begin
            @(negedge clock_i);
            k = k + 1;
         end
         tick;
         cmp(tcq_data_o, exp);
         tcq_pop_i = 1'b1;
         tick;
         tcq_pop_i = 1'b0;
         tick;
      end
   endtask

   ////////////////////////////////////////
   task t_types;
      integer t;
      begin
         for (t = 0; t < 4; t = t + 1) begin
            desc(4'hf, 1'b1, t[7:0], 16'h0040, 16'h0700, 16'h0001);
            token(`USBE_TOK_IN, 4'hf);
            exp_hs(t != `USBE_TYPE_ISO, `USBE_HS_NAK);
         end
         desc(4'hf, 1'b1, 8'h0a, 16'h0040, 16'h0700, 16'h0001);
         token(`USBE_TOK_IN, 4'hf);
         exp_hs(1'b1, `USBE_HS_STALL);
      end
   endtask

   task t_multi;
      integer i;
      begin
         slow = 1'b1;
         n0 = irq_cnt;
         for (i = 0; i < 5; i = i + 1)
            mem.ram[12'h400 + i[11:0]] = 8'h30 + i[7:0];
         desc(4'h1, 1'b1, 8'h12, 16'h0002, 16'h0400, 16'h0005);
         token(`USBE_TOK_IN, 4'h1);
         in_pkt(2, 12'h400, 1'b0);
         token(`USBE_TOK_IN, 4'h1);
         in_pkt(2, 12'h400, 1'b1);
         token(`USBE_TOK_IN, 4'h1);
         in_pkt(2, 12'h402, 1'b1);
         cmp(irq_cnt - n0, 0);
         token(`USBE_TOK_IN, 4'h1);
         in_pkt(1, 12'h404, 1'b1);
         pop(5'h03);
         cmp(irq_cnt - n0, 1);
         cmp(mem.ram[12'h118], 8'h22);
         cmp(mem.ram[12'h11B], 8'h05);
         cmp(mem.ram[12'h11D], 8'h00);
         slow = 1'b0;
      end
   endtask

   task t_out;
      integer i;
      integer k;
      begin
         tcq_irq_en_i = 1'b0;
         n0 = irq_cnt;
         desc(4'h4, 1'b0, 8'h13, 16'h0004, 16'h0500, 16'h0004);
         token(`USBE_TOK_OUT, 4'h4);
         rx_ok_i = 1'b1;
         for (i = 0; i < 4; i = i + 1) begin
            rx_valid_i = 1'b1;
            rx_data_i = 8'ha0 + i[7:0];
            k = 0;
            @(negedge clock_i);
            while (rx_ready_o !== 1'b1 && k < 100) begin
               @(negedge clock_i);
               k = k + 1;
            end
            tick;
         end
         rx_valid_i = 1'b0;
         rx_end_i = 1'b1;
         tick;
         rx_end_i = 1'b0;
         exp_hs(1'b1, `USBE_HS_ACK);
         pop(5'h08);
         for (i = 0; i < 4; i = i + 1)
            cmp(mem.ram[12'h500 + i[11:0]], 8'ha0 + i[7:0]);
         cmp(irq_cnt - n0, 0);
         tcq_irq_en_i = 1'b1;
      end
   endtask

   task t_pp;
      begin
         pp_en_i = 16'h0004;
         mem.ram[12'h600] = 8'h55;
         mem.ram[12'h601] = 8'haa;
         desc(4'h2, 1'b0, 8'h12, 16'h0001, 16'h0600, 16'h0001);
         desc(4'h2, 1'b1, 8'h12, 16'h0001, 16'h0601, 16'h0001);
         token(`USBE_TOK_IN, 4'h2);
         in_pkt(1, 12'h600, 1'b1);
         token(`USBE_TOK_IN, 4'h2);
         in_pkt(1, 12'h601, 1'b1);
         pop(5'h04);
         pop(5'h05);
         pp_en_i = 16'h0000;
      end
   endtask

   task t_power;
      integer s;
      integer k;
      begin
         for (s = 0; s < 2; s = s + 1) begin
            low_speed_i = s[0];
            line_q = !s[0];
            sleep_en_i = !s[0];
            traffic = 1'b0;
            k = 0;
            while (suspend_o !== 1'b1 && k < 8000) begin
               tick;
               k = k + 1;
            end
            tick;
            cmp({suspend_o, sleep_req_o}, {1'b1, !s[0]});
            line_q = s[0];
            k = 0;
            while (wake_o !== 1'b1 && k < 2000) begin
               @(negedge clock_i);
               k = k + 1;
            end
            cmp(wake_o, 1'b1);
            tick;
            traffic = 1'b1;
            k = 0;
            while (suspend_o !== 1'b0 && k < 4000) begin
               tick;
               k = k + 1;
            end
            cmp(suspend_o, 1'b0);
         end
         se0 = 1'b1;
         k = 0;
         while (bus_reset_o !== 1'b1 && k < 800) begin
            tick;
            k = k + 1;
         end
         cmp(bus_reset_o, 1'b1);
         se0 = 1'b0;
      end
   endtask

   initial begin
      repeat (4) @(posedge clock_i);
      #1;
      rstn_i = 1'b1;
      t_types;
      t_multi;
      t_out;
      t_pp;
      t_power;
      results;
   end
endmodule

bind usbe_engine usbe_engine_chk #(
   .TCQ_AW(TCQ_AW),
   .SUSP_FS(SUSP_FS),
   .SUSP_LS(SUSP_LS)
) u_chk (.*);
